// file: hdl/single_access_ram_defs.vh
// address map, block geometry and wait-state constants of the ram subsystem
`ifndef SINGLE_ACCESS_RAM_DEFS_VH
`define SINGLE_ACCESS_RAM_DEFS_VH

`define ADDR_W          22
`define DATA_W          16
`define WORD_ADDR_W     12
`define BLOCK_WORDS     4096
`define NUM_BLOCKS      8
`define BLK_SEL_W       3
`define DMA_CHANNELS    6
`define DMA_CH_W        3
`define LOW_BASE        22'h008000
`define LOW_TOP         22'h00ffff
`define MIRROR_BASE     22'h3f8000
`define MIRROR_TOP      22'h3fbfff
`define MIRRORED_BLOCKS 4
`define STACK_TOP       22'h00ffff
`define PROG_WAIT_UPPER 1
`define DATA_WAIT_UPPER 0

`endif

// file: hdl/ram_block.v
// one 4k x 16 single-access ram block with a single port
module ram_block (
  input  wire        clock,
  input  wire        en,
  input  wire        wr,
  input  wire [11:0] addr,
  input  wire [15:0] wdata,
  output reg  [15:0] rdata
);

  reg [15:0] mem [0:4095];

  // no reset on the array: contents are undefined after power-up
  always @(posedge clock) begin
    if (en) begin
      if (wr) begin
        mem[addr] <= wdata;
      end else begin
        rdata <= mem[addr];
      end
    end
  end

endmodule // ram_block

// file: hdl/single_access_ram.v
// ram subsystem: address decode, mirror aliasing, wait states, arbitration
`include "single_access_ram_defs.vh"

// Summary of operation
// R1: low blocks decode at low and mirror windows
// R2: both aliases reach the same storage
// R3: each block is 4k words, decoded alone
// R4: upper blocks: data zero, program one wait
// R5: program bus means fetch or program-space operand
// R6: upper blocks only in low window
// R7: all six dma channels reach upper blocks
// R8: stack accesses reach only the low 64k
// R9: fixed priority data, program, dma; stall rest
module single_access_ram (
  input  wire        clock,
  input  wire        rst_b,
  // data bus
  input  wire        d_req,
  input  wire        d_wr,
  input  wire        d_stack,
  input  wire [21:0] d_addr,
  input  wire [15:0] d_wdata,
  output wire        d_ready,
  output reg         d_rvalid,
  output wire [15:0] d_rdata,
  // program bus
  input  wire        p_req,
  input  wire        p_wr,
  input  wire [21:0] p_addr,
  input  wire [15:0] p_wdata,
  output wire        p_ready,
  output reg         p_rvalid,
  output wire [15:0] p_rdata,
  // dma
  input  wire        m_req,
  input  wire        m_wr,
  input  wire [2:0]  m_chan,
  input  wire [21:0] m_addr,
  input  wire [15:0] m_wdata,
  output wire        m_ready,
  output reg         m_rvalid,
  output reg  [2:0]  m_rchan,
  output wire [15:0] m_rdata
);

  // ****************************************
  // block geometry
  // ****************************************
  // the index picks one of eight 4k-word blocks; the word inside the
  // block is always the low twelve address bits, whichever alias is used
  localparam NB = `NUM_BLOCKS;
  localparam BW = `BLK_SEL_W;

  // ****************************************
  // data bus decode
  // ****************************************
  // a stack-relative access only reaches the low 64k, so it never
  // sees the mirror window and is dropped there
  wire       d_low  = d_addr >= `LOW_BASE && d_addr <= `LOW_TOP; // R1 R6
  wire       d_mir  = d_addr >= `MIRROR_BASE && d_addr <= `MIRROR_TOP;
  wire       d_mhit = d_mir && !d_stack; // R8
  wire [2:0] d_idx  = d_low ? d_addr[14:12] : {1'b0, d_addr[13:12]}; // R3
  wire [3:0] d_dec  = {d_low || d_mhit, d_idx}; // R1 R2

  // ****************************************
  // program bus decode
  // ****************************************
  // opcode fetches and program-space operands arrive here and may use
  // either alias of the lower blocks
  wire       p_low  = p_addr >= `LOW_BASE && p_addr <= `LOW_TOP; // R5
  wire       p_mir  = p_addr >= `MIRROR_BASE && p_addr <= `MIRROR_TOP;
  wire [2:0] p_idx  = p_low ? p_addr[14:12] : {1'b0, p_addr[13:12]};
  wire [3:0] p_dec  = {p_low || p_mir, p_idx}; // R1 R2

  // ****************************************
  // dma decode
  // ****************************************
  // dma reaches the upper four blocks only, on any of its channels;
  // anything else is taken at once and dropped
  wire       m_low  = m_addr >= `LOW_BASE && m_addr <= `LOW_TOP;
  wire       m_up   = m_low && m_addr[14]; // R6 R7
  wire [3:0] m_dec  = {m_up, m_addr[14:12]}; // R7

  wire d_hit = d_req && d_dec[3];
  wire p_hit = p_req && p_dec[3];
  wire m_hit = m_req && m_dec[3]; // R7

  // ****************************************
  // wait state on program access to upper blocks
  // ****************************************
  // the flag marks that the one wait cycle has been spent; it is cleared
  // by the take itself, so back-to-back fetches each pay their own wait
  // a mirror hit always has index bit 2 low, so only the upper blocks
  // in the low window ever wait
  reg        p_wait_done_r;
  wire       p_upper = p_dec[2];

  // ****************************************
  // arbitration
  // ****************************************
  // a block has one port: the data bus always wins, the program bus
  // comes next and dma last; the loser simply sees ready low
  wire p_conf  = d_hit && d_dec[2:0] == p_dec[2:0];
  wire m_dconf = d_hit && d_dec[2:0] == m_dec[2:0];
  wire m_pconf = p_hit && p_dec[2:0] == m_dec[2:0];
  wire m_conf  = m_dconf || m_pconf;
  wire d_go   = d_hit; // R9
  wire p_go   = p_hit && !p_conf &&
                (!p_upper || p_wait_done_r); // R4 R9
  wire m_go   = m_hit && !m_conf; // R9

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      p_wait_done_r <= 1'b0;
    end else if (p_hit && p_upper && !p_conf && !p_wait_done_r) begin
      p_wait_done_r <= 1'b1; // R4
    end else if (p_go) begin
      p_wait_done_r <= 1'b0;
    end
  end

  // ****************************************
  // ready
  // ****************************************
  // an unmapped address is acknowledged at once so a stray access can
  // never hang its bus; it has no effect on any block
  assign d_ready = !d_req || d_go || !d_hit;
  assign p_ready = !p_req || p_go || !p_hit;
  assign m_ready = !m_req || m_go || !m_hit;

  // ****************************************
  // blocks
  // ****************************************
  // each block gets at most one request per cycle, picked by the
  // arbitration above, so the port mux below needs no priority of its own
  wire [15:0]   rd [0:NB-1];
  reg  [BW-1:0] d_blk_r;
  reg  [BW-1:0] p_blk_r;
  reg  [BW-1:0] m_blk_r;

  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : blk
      wire ds = d_go && d_dec[2:0] == g;
      wire ps = p_go && p_dec[2:0] == g;
      wire ms = m_go && m_dec[2:0] == g;
      wire [21:0] a = ds ? d_addr : (ps ? p_addr : m_addr);
      wire        w = ds ? d_wr : (ps ? p_wr : m_wr);
      wire [15:0] wd = ds ? d_wdata : (ps ? p_wdata : m_wdata);
      ram_block u_ram (
        .clock (clock),
        .en    (ds || ps || ms),
        .wr    (w),
        .addr  (a[11:0]), // R2 R3
        .wdata (wd),
        .rdata (rd[g])
      );
    end
  endgenerate

  // ****************************************
  // read return
  // ****************************************
  // each bus flags its read one cycle after the take, when the addressed
  // block puts the word out; writes return nothing
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      d_rvalid <= 1'b0;
    end else begin
      d_rvalid <= d_go && !d_wr;
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      p_rvalid <= 1'b0;
    end else begin
      p_rvalid <= p_go && !p_wr;
    end
  end

  // the channel travels with the word so the dma engine can steer it
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      m_rvalid <= 1'b0;
      m_rchan  <= 3'h0;
    end else begin
      m_rvalid <= m_go && !m_wr;
      if (m_go) begin
        m_rchan <= m_chan;
      end
    end
  end

  // the block index is kept so each read mux follows the block that
  // answered, even if the bus has moved on to another address
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      d_blk_r <= 3'h0;
      p_blk_r <= 3'h0;
      m_blk_r <= 3'h0;
    end else begin
      d_blk_r <= d_dec[2:0];
      p_blk_r <= p_dec[2:0];
      m_blk_r <= m_dec[2:0];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  // the words come straight from the block output flops
  assign d_rdata = rd[d_blk_r];
  assign p_rdata = rd[p_blk_r];
  assign m_rdata = rd[m_blk_r];

endmodule // single_access_ram

// file: tb/single_access_ram_monitor.sv
// port checker for the ram subsystem
module single_access_ram_monitor (
  input wire logic        clock, rst_b, d_req, d_wr, d_stack, d_ready,
  input wire logic        d_rvalid, p_req, p_ready, m_req, m_wr, m_ready,
  input wire logic        m_rvalid,
  input wire logic [21:0] d_addr, p_addr, m_addr,
  input wire logic [2:0]  m_chan, m_rchan
);
  timeunit 1ns; timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire logic pu = p_addr[21:14] == 8'h03;
  wire logic mu = m_addr[21:14] == 8'h03 && m_chan < 3'h6;
  // stack accesses cannot use the mirror alias
  wire logic dm = d_addr[21:15] == 7'h01 ||
                  !d_stack && d_addr[21:14] == 8'hfe;
  property p_d_go; d_req |-> d_ready; endproperty
  a_d_go: assert property (p_d_go) else $error("data stalled");
  property p_d_rd; d_req && d_ready && dm && !d_wr |=> d_rvalid; endproperty
  a_d_rd: assert property (p_d_rd) else $error("data read lost");
  property p_p_ws; $rose(p_req) && pu |-> !p_ready; endproperty
  a_p_ws: assert property (p_p_ws) else $error("no wait state");
  property p_p_one; $rose(p_req) && pu && !d_req |=> p_ready || d_req;
  endproperty
  a_p_one: assert property (p_p_one) else $error("wait too long");
  property p_p_low; p_req && p_addr[21:14] == 8'h02 && !d_req |-> p_ready;
  endproperty
  a_p_low: assert property (p_p_low) else $error("low block wait");
  property p_m_up; m_req && mu && !d_req && !p_req |-> m_ready; endproperty
  a_m_up: assert property (p_m_up) else $error("dma refused");
  property p_m_rv;
    m_req && m_ready && mu && !m_wr |=> m_rvalid && m_rchan == $past(m_chan);
  endproperty
  a_m_rv: assert property (p_m_rv) else $error("dma read wrong");
  property p_stk; d_req && d_stack && d_addr[21:14] == 8'hfe |=> !d_rvalid;
  endproperty
  a_stk: assert property (p_stk) else $error("stack hit mirror");
  c_wait: cover property (p_req && !p_ready);
  c_stack: cover property (d_req && d_stack);
  c_dma: cover property (m_rvalid);
  c_both: cover property (d_req && p_req && !p_ready);
endmodule // single_access_ram_monitor

bind single_access_ram single_access_ram_monitor i_mon (.*);

// file: tb/bus_master.sv
// requester model: one bus request at a time, held until taken, except pair, which raises data and program together
module bus_master (
  input wire logic         clock, d_ready, p_ready, m_ready,
  output logic             d_req, p_req, m_req, d_stack, wr,
  output logic [21:0]      addr,
  output logic [15:0]      wdata,
  output logic [2:0]       chan
);
  timeunit 1ns; timeprecision 1ps;
  initial {d_req, p_req, m_req, d_stack, wr, addr, wdata, chan} = '0;
  // b: 0 data, 1 program, 2 dma, 3 data as stack access
  task go(input logic [1:0] b, input logic w, input logic [21:0] a,
          input logic [15:0] v, input logic [2:0] c);
    logic [2:0] r;
    r = b == 2'h3 ? 3'h1 : 3'h1 << b;
    @(posedge clock);
    {m_req, p_req, d_req} <= r;
    d_stack <= b == 2'h3;
    wr <= w; addr <= a; wdata <= v; chan <= c;
    #1;
    while (!(r & {m_ready, p_ready, d_ready})) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    {m_req, p_req, d_req} <= 3'h0;
    addr <= ~a;
    wdata <= ~v;
  endtask
  // data and program read one block together; program must wait its turn
  task pair(input logic [21:0] a);
    @(posedge clock);
    {p_req, d_req} <= 2'h3;
    d_stack <= 1'b0;
    wr <= 1'b0; addr <= a;
    #1;
    while (!d_ready) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    d_req <= 1'b0;
    #1;
    while (!p_ready) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    p_req <= 1'b0;
    addr <= ~a;
  endtask
endmodule // bus_master

// file: tb/tb.sv
// testbench: aliasing, wait states, dma reach and stack reach
module tb;
  timeunit 1ns; timeprecision 1ps;
  logic clock = 0, rst_b = 0, d_req, p_req, m_req, d_stack, wr;
  logic [21:0] addr, a;
  logic [15:0] wdata, v, exp_q[$];
  logic [2:0] chan, ch_q[$];
  wire logic d_ready, d_rvalid, p_ready, p_rvalid, m_ready, m_rvalid;
  wire logic [15:0] d_rdata, p_rdata, m_rdata;
  wire logic [2:0] m_rchan;
  int errors = 0, n_compared = 0, cyc = 0;
  single_access_ram i_dut (.*, .d_wr(wr), .p_wr(wr), .m_wr(wr),
    .d_addr(addr), .p_addr(addr), .m_addr(addr), .d_wdata(wdata),
    .p_wdata(wdata), .m_wdata(wdata), .m_chan(chan));
  bus_master i_bus (.*);
  always #2.5 clock = ~clock;
  task check(input logic [15:0] e, s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value rdata exp %h seen %h", e, s);
    end
  endtask
  task check_chan(input logic [2:0] e, s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value m_rchan exp %h seen %h", e, s);
    end
  endtask
  task finish_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      finish_test;
    end
    if (d_rvalid === 1'b1 || p_rvalid === 1'b1 || m_rvalid === 1'b1)
      check(exp_q.size() ? exp_q.pop_front() : 16'hxxxx, d_rvalid === 1'b1 ?
            d_rdata : p_rvalid === 1'b1 ? p_rdata : m_rdata);
    if (m_rvalid === 1'b1)
      check_chan(ch_q.size() ? ch_q.pop_front() : 3'hx, m_rchan);
  end
  initial begin
    void'($urandom(52));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      v = $urandom;
      a = {8'h0, k[1:0], v[11:0]};
      if (k < 4) begin
        i_bus.go(2'h0, 1'b1, 22'h3f8000 + a, v, 3'h0);
        exp_q.push_back(v);
        i_bus.go(2'h1, 1'b0, 22'h008000 + a, v, 3'h0);
        exp_q.push_back(v);
        i_bus.go(2'h3, 1'b0, 22'h008000 + a, v, 3'h0);
        exp_q.push_back(v);
        exp_q.push_back(v);
        i_bus.pair(22'h008000 + a);
      end else begin
        i_bus.go(2'h2, 1'b1, 22'h00c000 + a, v, 3'(k - 4));
        exp_q.push_back(v);
        i_bus.go(2'h1, 1'b0, 22'h00c000 + a, v, 3'h0);
        exp_q.push_back(v);
        ch_q.push_back(3'(k - 4));
        i_bus.go(2'h2, 1'b0, 22'h00c000 + a, v, 3'(k - 4));
      end
    end
    i_bus.go(2'h3, 1'b0, 22'h3f8000, v, 3'h0);
    i_bus.go(2'h0, 1'b0, 22'h3fc000, v, 3'h0);
    repeat (3) @(posedge clock);
    check(16'h0000, 16'(exp_q.size()));
    finish_test;
  end
endmodule // tb
